// ===== core/ncrp_pkg.sv
// Constants, states and register map for the clock-reference packet receiver.
// Behaviour
// - Control 11 means clock reference plus payload with delay tables.
// - The pointer counts bytes before the section; zero means it follows directly.
// - Section opens with 64-bit private header then 8-bit forward count.
// - Forward count is entries minus one; zero means one entry.
// - Forward entry: 8-bit sat_ident, 8-bit hub id, 32-bit delay.
// - Delays are clock-reference counts; forward is hub to satellite.
// - Return delay is satellite down to the traffic gateway.
// - Then 8-bit return count, entries minus one, zero means one.
// - Return entry: 8-bit sat_ident, 8-bit gw_ident, 32-bit delay.
// - Then 8-bit descriptor byte length; receiver skips that many bytes.
// - Section ends with a 32-bit CRC over the whole section.
// - The terminal may use the delays for its own timing; optional.
package ncrp_pkg;

  localparam int          AXI_ADDR_W      = 8;
  localparam logic [7:0]  SYNC_BYTE       = 8'h47;
  localparam logic [7:0]  POS_HDR_FLAGS   = 8'h01;
  localparam logic [7:0]  POS_PID_LO      = 8'h02;
  localparam logic [7:0]  POS_AF_LEN      = 8'h04;
  localparam logic [7:0]  POS_AF_FLAGS    = 8'h05;
  localparam logic [7:0]  POS_PCR_LAST    = 8'h0b;
  localparam logic [7:0]  LAST_POS        = 8'hbb;
  localparam logic [7:0]  AF_LEN          = 8'h07;
  localparam logic [7:0]  AF_FLAGS        = 8'h10;
  localparam logic [1:0]  AFC_PCR_PAYLOAD = 2'h3;
  localparam logic [7:0]  SEC_HDR_BYTES   = 8'h08;
  localparam logic [7:0]  ENTRY_BYTES     = 8'h06;
  localparam logic [7:0]  CRC_BYTES       = 8'h04;
  localparam int          PCR_BASE_LSB    = 15;
  localparam int          PCR_EXT_W       = 9;
  localparam int          ENT_SEL_RET_BIT = 8;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL    = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_PID     = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS  = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_NCR_LO  = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] REG_NCR_HI  = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] REG_TBLINFO = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] REG_ENTSEL  = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] REG_ENTID   = 8'h1c;
  localparam logic [AXI_ADDR_W-1:0] REG_ENTDLY  = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] REG_CRC     = 8'h24;
  localparam logic [AXI_ADDR_W-1:0] REG_PKTCNT  = 8'h28;

  localparam logic        CTRL_RST   = 1'b0;
  localparam logic [12:0] PID_RST    = 13'h0000;
  localparam int          ST_SYNC    = 0;
  localparam int          ST_HDRERR  = 1;
  localparam int          ST_AFERR   = 2;
  localparam int          ST_OVF     = 3;
  localparam int          ST_TBL     = 4;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  typedef enum logic [12:0] {
    PS_WAIT   = 13'h0001,
    PS_HDR    = 13'h0002,
    PS_ADAPT  = 13'h0004,
    PS_PTR    = 13'h0008,
    PS_SKIP   = 13'h0010,
    PS_SECHDR = 13'h0020,
    PS_FCNT   = 13'h0040,
    PS_FENT   = 13'h0080,
    PS_RCNT   = 13'h0100,
    PS_RENT   = 13'h0200,
    PS_DLEN   = 13'h0400,
    PS_DESC   = 13'h0800,
    PS_CRC    = 13'h1000
  } ncrp_state_e;

endpackage

// ===== core/ncrp_reg_if.sv
// Link between the packet parser and its register bank.
`timescale 1ns/100ps
`default_nettype none
interface ncrp_reg_if;
  logic        enable;
  logic [12:0] pidCfg;
  logic [8:0]  entSel;
  logic        evSync;
  logic        evHdr;
  logic        evAf;
  logic        evOvf;
  logic        evTbl;
  logic        evNcr;
  logic [32:0] ncrBase;
  logic [8:0]  ncrExt;
  logic [1:0]  tsc;
  logic [7:0]  fwdCnt;
  logic [7:0]  retCnt;
  logic [7:0]  descLen;
  logic [31:0] crcVal;
  logic [7:0]  entSat;
  logic [7:0]  entPeer;
  logic [31:0] entDly;

  modport regs (output enable, pidCfg, entSel,
                input  evSync, evHdr, evAf, evOvf, evTbl, evNcr, ncrBase, ncrExt, tsc,
                       fwdCnt, retCnt, descLen, crcVal, entSat, entPeer, entDly);
  modport core (input  enable, pidCfg, entSel,
                output evSync, evHdr, evAf, evOvf, evTbl, evNcr, ncrBase, ncrExt, tsc,
                       fwdCnt, retCnt, descLen, crcVal, entSat, entPeer, entDly);
endinterface
`default_nettype wire

// ===== core/ncrp_axil_regs.sv
// AXI4-Lite register bank of the clock-reference packet receiver.
`timescale 1ns/100ps
`default_nettype none
module ncrp_axil_regs
  import ncrp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  ncrp_reg_if.regs                   rb
);

  logic                  awready_q, awready_d, wready_q, wready_d, awHave_q, awHave_d, wHave_q, wHave_d;
  logic                  bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
  logic [AXI_ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0]           wData_q, wData_d, rdata_q, rdata_d, pktCnt_q, pktCnt_d;
  logic [3:0]            wStrb_q, wStrb_d;
  logic                  ctrl_q, ctrl_d;
  logic [12:0]           pid_q, pid_d;
  logic [8:0]            sel_q, sel_d;
  logic [4:0]            status_q, status_d, statusSet, statusClr;
  logic [33:0]           wrLook;
  logic [31:0]           wrWord;

  function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [33:0] readReg(input logic [AXI_ADDR_W-1:0] a);
    logic [31:0] v;
    logic [1:0]  e;
    v = 32'h0000_0000;
    e = RESP_OKAY;
    if (a == REG_CTRL) v = {31'h0000_0000, ctrl_q};
    else if (a == REG_PID) v = {19'h0_0000, pid_q};
    else if (a == REG_STATUS) v = {27'h000_0000, status_q};
    else if (a == REG_NCR_LO) v = rb.ncrBase[31:0];
    else if (a == REG_NCR_HI) v = {7'h00, rb.ncrExt, 15'h0000, rb.ncrBase[32]};
    else if (a == REG_TBLINFO) v = {6'h00, rb.tsc, rb.descLen, rb.retCnt, rb.fwdCnt};
    else if (a == REG_ENTSEL) v = {23'h00_0000, sel_q};
    else if (a == REG_ENTID) v = {16'h0000, rb.entPeer, rb.entSat};
    else if (a == REG_ENTDLY) v = rb.entDly;
    else if (a == REG_CRC) v = rb.crcVal;
    else if (a == REG_PKTCNT) v = pktCnt_q;
    else e = RESP_SLV;
    return {e, v};
  endfunction

  always_comb begin
    awready_d = awready_q; wready_d = wready_q; awHave_d = awHave_q; wHave_d = wHave_q;
    awAddr_d = awAddr_q; wData_d = wData_q; wStrb_d = wStrb_q;
    bvalid_d = bvalid_q; bresp_d = bresp_q; arready_d = arready_q; rvalid_d = rvalid_q;
    rdata_d = rdata_q; rresp_d = rresp_q;
    ctrl_d = ctrl_q; pid_d = pid_q; sel_d = sel_q;
    statusClr = 5'h00;
    statusSet = {rb.evTbl, rb.evOvf, rb.evAf, rb.evHdr, rb.evSync};
    pktCnt_d = rb.evNcr ? pktCnt_q + 32'h0000_0001 : pktCnt_q;
    wrLook = readReg(awAddr_q);
    wrWord = applyStrb(wrLook[31:0], wData_q, wStrb_q);
    if (awvalid && awready_q) begin
      awHave_d = 1'b1; awAddr_d = awaddr; awready_d = 1'b0;
    end
    if (wvalid && wready_q) begin
      wHave_d = 1'b1; wData_d = wdata; wStrb_d = wstrb; wready_d = 1'b0;
    end
    if (awHave_q && wHave_q && !bvalid_q) begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      if (awAddr_q == REG_CTRL) ctrl_d = wrWord[0];
      else if (awAddr_q == REG_PID) pid_d = wrWord[12:0];
      else if (awAddr_q == REG_STATUS) statusClr = wData_q[4:0] & {5{wStrb_q[0]}};
      else if (awAddr_q == REG_ENTSEL) sel_d = wrWord[8:0];
      else if (wrLook[33:32] != RESP_OKAY) bresp_d = RESP_SLV;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0; awHave_d = 1'b0; wHave_d = 1'b0; awready_d = 1'b1; wready_d = 1'b1;
    end
    if (arvalid && arready_q) begin
      {rresp_d, rdata_d} = readReg(araddr);
      rvalid_d  = 1'b1;
      arready_d = 1'b0;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0; arready_d = 1'b1;
    end
    // Event in the clearing cycle survives
    status_d = (status_q & ~statusClr) | statusSet;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready_q <= 1'b1; wready_q <= 1'b1; awHave_q <= 1'b0; wHave_q <= 1'b0;
      awAddr_q <= '0; wData_q <= 32'h0000_0000; wStrb_q <= 4'h0;
      bvalid_q <= 1'b0; bresp_q <= RESP_OKAY; arready_q <= 1'b1; rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000; rresp_q <= RESP_OKAY;
      ctrl_q <= CTRL_RST; pid_q <= PID_RST; sel_q <= 9'h000; status_q <= 5'h00;
      pktCnt_q <= 32'h0000_0000;
    end else begin
      awready_q <= awready_d; wready_q <= wready_d; awHave_q <= awHave_d; wHave_q <= wHave_d;
      awAddr_q <= awAddr_d; wData_q <= wData_d; wStrb_q <= wStrb_d;
      bvalid_q <= bvalid_d; bresp_q <= bresp_d; arready_q <= arready_d; rvalid_q <= rvalid_d;
      rdata_q <= rdata_d; rresp_q <= rresp_d;
      ctrl_q <= ctrl_d; pid_q <= pid_d; sel_q <= sel_d; status_q <= status_d;
      pktCnt_q <= pktCnt_d;
    end
  end

  assign awready    = awready_q;
  assign wready     = wready_q;
  assign bvalid     = bvalid_q;
  assign bresp      = bresp_q;
  assign arready    = arready_q;
  assign rvalid     = rvalid_q;
  assign rdata      = rdata_q;
  assign rresp      = rresp_q;
  assign rb.enable  = ctrl_q;
  assign rb.pidCfg  = pid_q;
  assign rb.entSel  = sel_q;

endmodule // ncrp_axil_regs
`default_nettype wire

// ===== core/ncrp_ts_receiver.sv
// Terminal-side receiver of the clock-reference transport packet and its delay tables.
`timescale 1ns/100ps
`default_nettype none
module ncrp_ts_receiver
  import ncrp_pkg::*;
#(
  parameter int MAX_ENT = 32
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [7:0]            tsData,
  input  wire logic                  tsValid,
  input  wire logic                  tsStart,
  output logic                       ncrUpdate,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  localparam int IDX_W = (MAX_ENT > 1) ? $clog2(MAX_ENT) : 1;

  ncrp_reg_if bus ();

  ncrp_axil_regs u_regs (
    .clk     (clk),
    .rstn    (rstn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rb      (bus.regs)
  );

  ncrp_state_e  st_q, st_d;
  logic [7:0]   pos_q, pos_d, cnt_q, cnt_d, loop_q, loop_d, idx_q, idx_d;
  logic [4:0]   pidHi_q, pidHi_d;
  logic         pusi_q, pusi_d;
  logic [1:0]   afc_q, afc_d, tsc_q, tsc_d;
  logic [39:0]  sh_q, sh_d;
  logic [32:0]  ncrBase_q, ncrBase_d;
  logic [8:0]   ncrExt_q, ncrExt_d;
  logic [7:0]   fwdCnt_q, fwdCnt_d, retCnt_q, retCnt_d, descLen_q, descLen_d;
  logic [31:0]  crc_q, crc_d;
  logic         evSync_q, evSync_d, evHdr_q, evHdr_d, evAf_q, evAf_d;
  logic         evOvf_q, evOvf_d, evTbl_q, evTbl_d, evNcr_q, evNcr_d;
  logic         memWe, memRet;
  logic [47:0]  memData, pcrWord;
  logic [47:0]  fwdMem [MAX_ENT];
  logic [47:0]  retMem [MAX_ENT];
  logic [47:0]  entRd;
  logic         inSection;

  assign pcrWord   = {sh_q, tsData};
  assign memData   = {sh_q, tsData};
  assign inSection = st_q inside {PS_PTR, PS_SKIP, PS_SECHDR, PS_FCNT, PS_FENT, PS_RCNT, PS_RENT,
                                  PS_DLEN, PS_DESC, PS_CRC};

  always_comb begin
    st_d = st_q; pos_d = pos_q; cnt_d = cnt_q; loop_d = loop_q; idx_d = idx_q;
    pidHi_d = pidHi_q; pusi_d = pusi_q; afc_d = afc_q; tsc_d = tsc_q; sh_d = sh_q;
    ncrBase_d = ncrBase_q; ncrExt_d = ncrExt_q; fwdCnt_d = fwdCnt_q; retCnt_d = retCnt_q;
    descLen_d = descLen_q; crc_d = crc_q;
    evSync_d = 1'b0; evHdr_d = 1'b0; evAf_d = 1'b0; evOvf_d = 1'b0; evTbl_d = 1'b0; evNcr_d = 1'b0;
    memWe = 1'b0; memRet = 1'b0;
    if (tsValid) begin
      pos_d = pos_q + 8'h01;
      sh_d  = {sh_q[31:0], tsData};
      cnt_d = cnt_q - 8'h01;
      if (tsStart) begin
        // Any start byte resynchronises, even mid-section
        pos_d = POS_HDR_FLAGS;
        st_d  = (tsData == SYNC_BYTE && bus.enable) ? PS_HDR : PS_WAIT;
        evSync_d = (tsData != SYNC_BYTE);
      end else begin
        case (st_q)
          PS_WAIT: begin
            pos_d = pos_q;
          end
          PS_HDR: begin
            if (pos_q == POS_HDR_FLAGS) begin
              pusi_d  = tsData[6];
              pidHi_d = tsData[4:0];
              if (tsData[7] || tsData[5]) begin
                evHdr_d = 1'b1;
                st_d    = PS_WAIT;
              end
            end else if (pos_q == POS_PID_LO) begin
              if ({pidHi_q, tsData} != bus.pidCfg) st_d = PS_WAIT;
            end else begin
              tsc_d = tsData[7:6];
              afc_d = tsData[5:4];
              if (!tsData[5]) begin
                evAf_d = 1'b1;
                st_d   = PS_WAIT;
              end else begin
                st_d = PS_ADAPT;
              end
            end
          end
          PS_ADAPT: begin
            if (pos_q == POS_AF_LEN && tsData != AF_LEN) begin
              evAf_d = 1'b1;
              st_d   = PS_WAIT;
            end else if (pos_q == POS_AF_FLAGS && tsData != AF_FLAGS) begin
              evAf_d = 1'b1;
              st_d   = PS_WAIT;
            end else if (pos_q == POS_PCR_LAST) begin
              // Reserved bits between base and extension are not checked
              ncrBase_d = pcrWord[47:PCR_BASE_LSB];
              ncrExt_d  = pcrWord[PCR_EXT_W-1:0];
              evNcr_d   = 1'b1;
              // Payload without a section start carries no table for us
              st_d = (afc_q == AFC_PCR_PAYLOAD && pusi_q) ? PS_PTR : PS_WAIT;
            end
          end
          PS_PTR: begin
            cnt_d = (tsData == 8'h00) ? SEC_HDR_BYTES : tsData;
            st_d  = (tsData == 8'h00) ? PS_SECHDR : PS_SKIP;
          end
          PS_SKIP: begin
            if (cnt_q == 8'h01) begin
              cnt_d = SEC_HDR_BYTES;
              st_d  = PS_SECHDR;
            end
          end
          PS_SECHDR: begin
            if (cnt_q == 8'h01) st_d = PS_FCNT;
          end
          PS_FCNT, PS_RCNT: begin
            if (st_q == PS_FCNT) fwdCnt_d = tsData;
            else retCnt_d = tsData;
            loop_d = tsData;
            idx_d  = 8'h00;
            cnt_d  = ENTRY_BYTES;
            st_d   = (st_q == PS_FCNT) ? PS_FENT : PS_RENT;
          end
          PS_FENT, PS_RENT: begin
            if (cnt_q == 8'h01) begin
              // Entries beyond storage are parsed but dropped
              memWe  = (idx_q < 8'(MAX_ENT));
              memRet = (st_q == PS_RENT);
              idx_d  = idx_q + 8'h01;
              cnt_d  = ENTRY_BYTES;
              loop_d = loop_q - 8'h01;
              if (loop_q == 8'h00) st_d = (st_q == PS_FENT) ? PS_RCNT : PS_DLEN;
            end
          end
          PS_DLEN: begin
            descLen_d = tsData;
            cnt_d = (tsData == 8'h00) ? CRC_BYTES : tsData;
            st_d  = (tsData == 8'h00) ? PS_CRC : PS_DESC;
          end
          PS_DESC: begin
            if (cnt_q == 8'h01) begin
              cnt_d = CRC_BYTES;
              st_d  = PS_CRC;
            end
          end
          PS_CRC: begin
            if (cnt_q == 8'h01) begin
              crc_d   = pcrWord[31:0];
              evTbl_d = 1'b1;
              st_d    = PS_WAIT;
            end
          end
          default: st_d = PS_WAIT;
        endcase
        // A section still open at the last packet byte is broken
        if (inSection && pos_q == LAST_POS && !(st_q == PS_CRC && cnt_q == 8'h01)) begin
          evOvf_d = 1'b1;
          st_d    = PS_WAIT;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= PS_WAIT; pos_q <= 8'h00; cnt_q <= 8'h00; loop_q <= 8'h00; idx_q <= 8'h00;
      pidHi_q <= 5'h00; pusi_q <= 1'b0; afc_q <= 2'h0; tsc_q <= 2'h0; sh_q <= 40'h00_0000_0000;
      ncrBase_q <= 33'h0_0000_0000; ncrExt_q <= 9'h000; fwdCnt_q <= 8'h00; retCnt_q <= 8'h00;
      descLen_q <= 8'h00; crc_q <= 32'h0000_0000;
      evSync_q <= 1'b0; evHdr_q <= 1'b0; evAf_q <= 1'b0; evOvf_q <= 1'b0; evTbl_q <= 1'b0; evNcr_q <= 1'b0;
    end else begin
      st_q <= st_d; pos_q <= pos_d; cnt_q <= cnt_d; loop_q <= loop_d; idx_q <= idx_d;
      pidHi_q <= pidHi_d; pusi_q <= pusi_d; afc_q <= afc_d; tsc_q <= tsc_d; sh_q <= sh_d;
      ncrBase_q <= ncrBase_d; ncrExt_q <= ncrExt_d; fwdCnt_q <= fwdCnt_d; retCnt_q <= retCnt_d;
      descLen_q <= descLen_d; crc_q <= crc_d;
      evSync_q <= evSync_d; evHdr_q <= evHdr_d; evAf_q <= evAf_d; evOvf_q <= evOvf_d;
      evTbl_q <= evTbl_d; evNcr_q <= evNcr_d;
    end
  end

  // Table memory has no reset; entries are valid once a table event is seen
  always_ff @(posedge clk) begin
    if (memWe && !memRet) fwdMem[idx_q[IDX_W-1:0]] <= memData;
    if (memWe && memRet) retMem[idx_q[IDX_W-1:0]] <= memData;
  end

  assign entRd = bus.entSel[ENT_SEL_RET_BIT] ? retMem[bus.entSel[IDX_W-1:0]] : fwdMem[bus.entSel[IDX_W-1:0]];

  assign bus.evSync  = evSync_q;
  assign bus.evHdr   = evHdr_q;
  assign bus.evAf    = evAf_q;
  assign bus.evOvf   = evOvf_q;
  assign bus.evTbl   = evTbl_q;
  assign bus.evNcr   = evNcr_q;
  assign bus.ncrBase = ncrBase_q;
  assign bus.ncrExt  = ncrExt_q;
  assign bus.tsc     = tsc_q;
  assign bus.fwdCnt  = fwdCnt_q;
  assign bus.retCnt  = retCnt_q;
  assign bus.descLen = descLen_q;
  assign bus.crcVal  = crc_q;
  assign bus.entSat  = entRd[47:40];
  assign bus.entPeer = entRd[39:32];
  assign bus.entDly  = entRd[31:0];
  assign ncrUpdate   = evNcr_q;

endmodule // ncrp_ts_receiver
`default_nettype wire

// ===== dv/ncrp_monitor.sv
// Assertions on the receiver's stream and bus ports.
`timescale 1ns/100ps
`default_nettype none
module ncrp_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tsValid,
  input wire logic ncrUpdate,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ncr_gap: assert property (ncrUpdate |=> !ncrUpdate [*8]) else $error("update pulse repeated");
  a_ncr_cause: assert property (ncrUpdate |-> $past(tsValid)) else $error("update without byte");
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no write answer");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write answer stuck");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("no read answer");
  a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer stuck");
  a_rst_idle: assert property ($rose(rstn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid)
    else $error("bad state after reset");
  c_ncr: cover property (ncrUpdate);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule // ncrp_monitor
bind ncrp_ts_receiver ncrp_monitor u_mon (.clk, .rstn, .tsValid, .ncrUpdate, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

// ===== dv/ncrp_hub_model.sv
// Behavioural hub that sends clock-reference packets.
`timescale 1ns/100ps
`default_nettype none
module ncrp_hub_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        send,
  input  wire logic        withTbl,
  input  wire logic [1:0]  fault,
  input  wire logic [12:0] pid,
  input  wire logic [32:0] base,
  input  wire logic [8:0]  ext,
  output logic [7:0]       tsData,
  output logic             tsValid,
  output logic             tsStart,
  output logic             busy
);
  // Pointer, header, one forward and two return entries, descriptors, check word
  localparam logic [287:0] SEC = 288'h00c0_c1c2_c3c4_c5c6_c700_1122_a1b2_c3d4_0130_4050_0000_0031_4150_0000_0102_eeee_5ac3_960f;
  logic [7:0]  pkt [188];
  logic [47:0] pcr;
  int          pos;
  assign busy = pos < 188;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos <= 188;
      tsValid <= 1'b0;
      tsStart <= 1'b0;
      tsData <= 8'h00;
    end else if (send && !busy) begin
      pcr = {base, 6'h3f, ext};
      for (int i = 0; i < 188; i++) pkt[i] = 8'hff;
      pkt[0] = (fault == 2'h3) ? 8'h46 : 8'h47;
      pkt[1] = {fault == 2'h1, withTbl, 1'b0, pid[12:8]};
      pkt[2] = pid[7:0];
      pkt[3] = {2'b00, 1'b1, withTbl, 4'h0};
      pkt[4] = (fault == 2'h2) ? 8'h06 : 8'h07;
      pkt[5] = 8'h10;
      for (int i = 0; i < 6; i++) pkt[6 + i] = pcr[47 - 8 * i -: 8];
      if (withTbl) for (int i = 0; i < 36; i++) pkt[12 + i] = SEC[287 - 8 * i -: 8];
      pos <= 0;
    end else if (busy) begin
      tsValid <= 1'b1;
      tsStart <= pos == 0;
      tsData <= pkt[pos];
      pos <= pos + 1;
    end else begin
      // Idle bytes toggle so a stale value is never mistaken for data
      tsValid <= 1'b0;
      tsStart <= 1'b0;
      tsData <= ~tsData;
    end
  end
endmodule // ncrp_hub_model
`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the clock-reference packet receiver.
`timescale 1ns/100ps
`default_nettype none
module tb
  import ncrp_pkg::*;
;
  logic        clk, rstn, send, withTbl, tsValid, tsStart, busy, ncrUpdate;
  logic [1:0]  fault, bResp, rResp;
  logic [7:0]  tsData, awAddr, arAddr;
  logic [12:0] pid;
  logic [31:0] wData, rData;
  logic        awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  int          errorCnt, cmpCount, ncrCnt;
  ncrp_hub_model u_hub (.clk, .rstn, .send, .withTbl, .fault, .pid, .base(33'h1_2345_6789), .ext(9'h1ab),
    .tsData, .tsValid, .tsStart, .busy);
  ncrp_ts_receiver #(.MAX_ENT(4)) u_dut (.clk, .rstn, .tsData, .tsValid, .tsStart, .ncrUpdate,
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (ncrUpdate === 1'b1) ncrCnt++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    forever begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) break;
    end
    bReady <= 1'b0;
    chk(bResp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    forever begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      if (rValid) break;
    end
    rReady <= 1'b0;
    chk(rData, exp);
    chk(rResp, er);
  endtask
  // Send one packet and wait until it has fully passed
  task automatic pkt(input logic t, input logic [1:0] f, input logic [12:0] p);
    withTbl <= t;
    fault <= f;
    pid <= p;
    send <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 300 && busy; i++) @(posedge clk);
    chk(busy, 0);
    repeat (3) @(posedge clk);
  endtask
  task automatic t_regs;
    rd(REG_CTRL, 32'h0000_0000, RESP_OKAY);
    rd(REG_STATUS, 32'h0000_0000, RESP_OKAY);
    rd(8'h3c, 32'h0000_0000, RESP_SLV);
    wr(8'h3c, 32'h0000_0001, RESP_SLV);
    wr(REG_PID, 32'h0000_0123, RESP_OKAY);
    rd(REG_PID, 32'h0000_0123, RESP_OKAY);
    pkt(1'b0, 2'h0, 13'h0123);
    chk(ncrCnt, 0);
    $display("registers and disabled receive done");
  endtask
  task automatic t_pcr;
    wr(REG_CTRL, 32'h0000_0001, RESP_OKAY);
    pkt(1'b0, 2'h0, 13'h0123);
    chk(ncrCnt, 1);
    rd(REG_NCR_LO, 32'h2345_6789, RESP_OKAY);
    rd(REG_NCR_HI, 32'h01ab_0001, RESP_OKAY);
    rd(REG_PKTCNT, 32'h0000_0001, RESP_OKAY);
    $display("reference only done");
  endtask
  task automatic t_tbl;
    wr(REG_STATUS, 32'h0000_001f, RESP_OKAY);
    pkt(1'b1, 2'h0, 13'h0123);
    chk(ncrCnt, 2);
    rd(REG_STATUS, 32'h0000_0010, RESP_OKAY);
    rd(REG_TBLINFO, 32'h0002_0100, RESP_OKAY);
    wr(REG_ENTSEL, 32'h0000_0000, RESP_OKAY);
    rd(REG_ENTID, 32'h0000_2211, RESP_OKAY);
    rd(REG_ENTDLY, 32'ha1b2_c3d4, RESP_OKAY);
    wr(REG_ENTSEL, 32'h0000_0101, RESP_OKAY);
    rd(REG_ENTID, 32'h0000_4131, RESP_OKAY);
    rd(REG_ENTDLY, 32'h5000_0001, RESP_OKAY);
    rd(REG_CRC, 32'h5ac3_960f, RESP_OKAY);
    $display("delay table done");
  endtask
  task automatic t_bad;
    wr(REG_STATUS, 32'h0000_001f, RESP_OKAY);
    pkt(1'b0, 2'h1, 13'h0123);
    rd(REG_STATUS, 32'h0000_0002, RESP_OKAY);
    wr(REG_STATUS, 32'h0000_001f, RESP_OKAY);
    pkt(1'b0, 2'h2, 13'h0123);
    pkt(1'b0, 2'h0, 13'h0124);
    pkt(1'b0, 2'h3, 13'h0123);
    rd(REG_STATUS, 32'h0000_0005, RESP_OKAY);
    chk(ncrCnt, 2);
    $display("faulty packets done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    {send, withTbl, fault, pid, awValid, wValid, bReady, arValid, rReady, awAddr, arAddr, wData} = '0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_pcr();
    t_tbl();
    t_bad();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule // tb
`default_nettype wire
